// File: bench/ppf_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module ppf_pin_model (
  // clock
  input wire logic core_clk,
  // device side
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pull_en,
  // board side
  input wire logic [7:0] ext_lvl,
  input wire logic [7:0] ext_en,
  output logic [7:0] pin_in
);
  logic [7:0] drift = 8'h00;
  // undriven pins without pull wander every cycle
  always @(posedge core_clk) drift <= ~drift;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_lvl)
    | (~pin_oe & ~ext_en & (pin_pull_en | drift));
endmodule
`default_nettype wire

// File: bench/ppf_port_props.sv
`timescale 1ns/1ps
`default_nettype none
module ppf_port_props (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // bus
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // pins and interrupt
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pull_en,
  input wire logic irq
);
  logic take;
  logic rd;
  logic wclr;
  assign take = hsel && hready && htrans[1];
  assign rd = take && !hwrite;
  assign wclr = take && hwrite && (haddr == 12'h01c || haddr == 12'h014);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  chk_ready_high: assert property (hreadyout)
    else $error("ready went low");
  chk_resp_okay: assert property (!hresp)
    else $error("error response");
  chk_pull_out: assert property ((pin_pull_en & pin_oe) == 8'h00)
    else $error("pull device on driven pin");
  chk_rsvd_zero: assert property (rd && haddr >= 12'h02c && haddr <= 12'h03c |=> hrdata == 32'h0)
    else $error("reserved slot read nonzero");
  chk_upper_zero: assert property (rd |=> hrdata[31:8] == 24'h0)
    else $error("upper read bits nonzero");
  chk_rdata_hold: assert property (!rd |=> $stable(hrdata))
    else $error("read data moved without read");
  chk_irq_fall: assert property ($fell(irq) |-> $past(wclr, 2) || $past(wclr, 3))
    else $error("request dropped without clear");
  chk_irq_off: assert property (take && hwrite && haddr == 12'h014 ##1 hwdata[7:0] == 8'h00 |-> ##[1:2] !irq)
    else $error("request stayed with enables off");
endmodule
bind ppf_port ppf_port_props ppf_port_props_inst (.core_clk(core_clk), .reset_n(reset_n), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .pin_oe(pin_oe), .pin_pull_en(pin_pull_en), .irq(irq));
`default_nettype wire

// File: bench/ppf_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module ppf_port_tb_top;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic hsel = 1'b0, hwrite = 1'b0, stop_mode = 1'b0, hreadyout, hresp, irq;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'b00;
  logic [31:0] hwdata = 32'h0, hrdata, r;
  logic [7:0] pin_in, pin_out, pin_oe, pin_pull_en, per_in, p, o;
  logic [7:0] per_out = 8'h00, per_oe = 8'h00, ext_lvl = 8'h00, ext_en = 8'hff;
  logic [15:0] seed = 16'd18558;
  logic [31:0] mdl [16];
  int error_cnt = 0, samples_checked = 0, n;
  always #25 core_clk = ~core_clk;
  ppf_port ppf_port_inst (.core_clk(core_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pull_en(pin_pull_en), .per_out(per_out), .per_oe(per_oe),
    .per_in(per_in), .stop_mode(stop_mode), .irq(irq));
  ppf_pin_model ppf_pin_model_inst (.core_clk(core_clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pull_en(pin_pull_en), .ext_lvl(ext_lvl), .ext_en(ext_en), .pin_in(pin_in));
  function automatic [15:0] lfsr(input [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string nm, input [31:0] seen, input [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic xfer(input [11:0] a, input w, input [31:0] d);
    hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'b10;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00; hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    r = hrdata;
    if (w && a[5:2] inside {0, 1, 2, 3, 5, 8}) mdl[a[5:2]] = d & 32'hff;
  endtask
  task automatic wait_irq(input int lim);
    n = 0;
    while (irq !== 1'b1 && n < lim) begin @(posedge core_clk); n++; end
  endtask
  task complete_run;
    $display("errors %0d comparisons %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #(50 * 20000);
    error_cnt++;
    complete_run;
  end
  initial begin
    foreach (mdl[i]) mdl[i] = 32'h0;
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    repeat (3) begin
      for (int a = 0; a < 16; a++) if (!(a inside {6, 7, 9})) begin
        xfer(a * 4, 1'b0, 32'h0);
        chk("reg before", r, mdl[a]);
        seed = lfsr(seed);
        xfer(a * 4, 1'b1, {seed, lfsr(seed)}); // data goes before direction
        xfer(a * 4, 1'b0, 32'h0);
        chk("reg after", r, mdl[a]);
      end
      seed = lfsr(seed);
      per_oe <= seed[7:0];
      per_out <= seed[15:8];
      repeat (3) @(posedge core_clk);
      p = mdl[3][7:0];
      o = (p & per_oe) | (~p & mdl[2][7:0]);
      chk("pin_oe", pin_oe, o);
      chk("pin_out", pin_out, (p & per_out) | (~p & mdl[1][7:0]));
      chk("pull", pin_pull_en, mdl[0][7:0] & ~o);
      repeat (2) @(posedge core_clk);
      chk("per_in", per_in, o & ((p & per_out) | (~p & mdl[1][7:0])));
    end
    xfer(12'h00c, 1'b1, 32'h0);
    xfer(12'h008, 1'b1, 32'h0);
    xfer(12'h020, 1'b1, 32'h1);
    xfer(12'h014, 1'b1, 32'h1);
    repeat (10) @(posedge core_clk);
    xfer(12'h01c, 1'b1, 32'hff);
    ext_lvl <= 8'h01;
    repeat (3) @(posedge core_clk);
    ext_lvl <= 8'h00;
    repeat (12) @(posedge core_clk);
    chk("irq short pulse", irq, 1'b0);
    ext_lvl <= 8'h01;
    repeat (4) @(posedge core_clk);
    chk("irq early", irq, 1'b0);
    wait_irq(20);
    chk("irq edge", irq, 1'b1);
    xfer(12'h018, 1'b0, 32'h0);
    chk("status", r, 32'h1);
    xfer(12'h01c, 1'b1, 32'h1);
    repeat (3) @(posedge core_clk);
    chk("irq cleared", irq, 1'b0);
    ext_lvl <= 8'h00;
    stop_mode <= 1'b1;
    xfer(12'h028, 1'b0, 32'h0);
    chk("mode", r, 32'h1);
    repeat (40) @(posedge core_clk);
    ext_lvl <= 8'h01;
    repeat (10) @(posedge core_clk);
    chk("stop irq early", irq, 1'b0);
    wait_irq(60);
    chk("stop irq", irq, 1'b1);
    stop_mode <= 1'b0;
    xfer(12'h014, 1'b1, 32'h0);
    repeat (3) @(posedge core_clk);
    chk("irq masked", irq, 1'b0);
    ext_en <= 8'h00;
    repeat (3) @(posedge core_clk);
    xfer(12'h024, 1'b0, 32'h0);
    chk("pulled pins", r & mdl[0], mdl[0]);
    complete_run;
  end
endmodule
`default_nettype wire

// File: src/ppf_defs.vh
`ifndef PPF_DEFS_VH
`define PPF_DEFS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PPF_OFS_PULLUP   12'h000
`define PPF_OFS_DATA     12'h004
`define PPF_OFS_DIR      12'h008
`define PPF_OFS_PERSEL   12'h00c
`define PPF_OFS_PERIOD   12'h010
`define PPF_OFS_IRQ_EN   12'h014
`define PPF_OFS_IRQ_STAT 12'h018
`define PPF_OFS_IRQ_CLR  12'h01c
`define PPF_OFS_POLAR    12'h020
`define PPF_OFS_INPUT    12'h024
`define PPF_OFS_MODE     12'h028
`define PPF_OFS_RSVD_LO  12'h02c
`define PPF_OFS_RSVD_HI  12'h03c

// ----------------------------------------
// reset values and field positions
// ----------------------------------------
`define PPF_RST_BYTE     8'h00
`define PPF_RSVD_READ    32'h00000000
`define PPF_MODE_STOP_BIT 0

// ----------------------------------------
// filter timing
// ----------------------------------------
`define PPF_FILT_SAMPLES 3'h4
`define PPF_CNT_W        3

// ----------------------------------------
// ahb transfer types
// ----------------------------------------
`define PPF_HTRANS_NONSEQ 2'b10
`define PPF_HTRANS_SEQ    2'b11

`endif

// File: src/ppf_edge_filter.v
`timescale 1ns/1ps
`default_nettype none
`include "ppf_defs.vh"

// ----------------------------------------
// one-pin edge qualifier
// ----------------------------------------
// counts consecutive passive samples to arm, then consecutive active
// samples to fire; an interrupted active run restarts its count but stays armed
module ppf_edge_filter (
  // clock and reset
  input wire core_clk,
  input wire reset_n,
  // sampling
  input wire sample_en,
  input wire level,
  input wire active_high,
  // result
  output reg edge_ff,
  output wire low_count
);

  localparam [2:0] NEED = `PPF_FILT_SAMPLES;

  reg [2:0] pas_ff;
  reg [2:0] act_ff;
  reg armed_ff;
  wire is_act;

  assign is_act = (level == active_high);
  assign low_count = (pas_ff <= NEED) && (act_ff <= NEED);

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pas_ff <= 3'h0;
      act_ff <= 3'h0;
      armed_ff <= 1'b0;
      edge_ff <= 1'b0;
    end else begin
      edge_ff <= 1'b0;
      if (sample_en) begin
        if (!is_act) begin
          act_ff <= 3'h0;
          if (pas_ff != NEED) begin
            pas_ff <= pas_ff + 3'h1;
          end
          if (pas_ff == NEED - 3'h1) begin
            armed_ff <= 1'b1;
          end
        end else begin
          pas_ff <= 3'h0;
          if (armed_ff) begin
            if (act_ff == NEED - 3'h1) begin
              edge_ff <= 1'b1;
              armed_ff <= 1'b0;
              act_ff <= 3'h0;
            end else begin
              act_ff <= act_ff + 3'h1;
            end
          end
        end
      end
    end
  end

endmodule

`default_nettype wire

// File: src/ppf_port.v
`timescale 1ns/1ps
`default_nettype none
`include "ppf_defs.vh"

// Notes on behaviour
// - pull-up bit set enables pin pull device
// - output pins ignore their pull-up bit
// - reserved slots read zero, ignore writes
// - gpio on all but dedicated pins
// - any pin may carry peripheral signal
// - configuration writable anytime, override may mask
// - four passive then four active samples
// - run/wait: filters sampled every bus clock
// - stop: filters sampled by local oscillator
// - oscillator runs only while some enabled pin has its flag clear
module ppf_port #(
  parameter N = 8,
  parameter GPIO_MASK = 8'hff,
  parameter RC_DIV = 4
) (
  // clock and reset
  input wire core_clk,
  input wire reset_n,
  // ahb-lite slave
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // pins
  input wire [N-1:0] pin_in,
  output reg [N-1:0] pin_out,
  output reg [N-1:0] pin_oe,
  output reg [N-1:0] pin_pull_en,
  // peripheral side
  input wire [N-1:0] per_out,
  input wire [N-1:0] per_oe,
  output reg [N-1:0] per_in,
  // power mode
  input wire stop_mode,
  // interrupt
  output reg irq
);

  // ----------------------------------------
  // register state
  // ----------------------------------------
  reg [N-1:0] pullup_ff;
  reg [N-1:0] data_ff;
  reg [N-1:0] dir_ff;
  reg [N-1:0] persel_ff;
  reg [N-1:0] irq_en_ff;
  reg [N-1:0] flag_ff;
  reg [N-1:0] polar_ff;
  reg [N-1:0] sync1_ff;
  reg [N-1:0] sync2_ff;
  reg wr_pend_ff;
  reg [11:0] wr_addr_ff;

  wire [N-1:0] edge_hit;
  wire [N-1:0] low_cnt;
  wire rc_tick;
  wire rc_run;
  wire sample_en;
  wire [N-1:0] gpio_ok;
  wire [N-1:0] drv_oe;
  wire [N-1:0] drv_out;
  wire [N-1:0] flag_clr;
  wire addr_ph;

  function is_rsvd;
    input [11:0] a;
    begin
      is_rsvd = (a >= `PPF_OFS_RSVD_LO) && (a <= `PPF_OFS_RSVD_HI);
    end
  endfunction

  // a write landing in this data phase at the given offset
  function wr_hit;
    input pend;
    input [11:0] a;
    input [11:0] ofs;
    begin
      wr_hit = pend && (a == ofs);
    end
  endfunction

  // ----------------------------------------
  // input sync and pin muxing
  // ----------------------------------------
  assign gpio_ok = GPIO_MASK[N-1:0];
  genvar gp;
  generate
    for (gp = 0; gp < N; gp = gp + 1) begin : g_pin
      // a selected peripheral overrides gpio direction and data
      assign drv_oe[gp] = persel_ff[gp] ? per_oe[gp] : (dir_ff[gp] & gpio_ok[gp]);
      assign drv_out[gp] = persel_ff[gp] ? per_out[gp] : data_ff[gp];
    end
  endgenerate

  // two flops before any logic reads a pin
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_ff <= {N{1'b0}};
      sync2_ff <= {N{1'b0}};
    end else begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
    end
  end

  // ----------------------------------------
  // registered pin and request outputs
  // ----------------------------------------
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_out <= {N{1'b0}};
      pin_oe <= {N{1'b0}};
      pin_pull_en <= {N{1'b0}};
      per_in <= {N{1'b0}};
      irq <= 1'b0;
    end else begin
      pin_out <= drv_out;
      pin_oe <= drv_oe;
      pin_pull_en <= pullup_ff & ~drv_oe;
      per_in <= sync2_ff;
      irq <= |(flag_ff & irq_en_ff);
    end
  end

  // ----------------------------------------
  // edge filters and sample clocking
  // ----------------------------------------
  assign rc_run = stop_mode && |(low_cnt & irq_en_ff & ~flag_ff);
  assign sample_en = stop_mode ? rc_tick : 1'b1;

  ppf_rc_osc #(
    .DIV(RC_DIV)
  ) u_osc (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .run(rc_run),
    .tick_ff(rc_tick)
  );

  genvar gi;
  generate
    for (gi = 0; gi < N; gi = gi + 1) begin : g_filt
      ppf_edge_filter u_filt (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .sample_en(sample_en),
        .level(sync2_ff[gi]),
        .active_high(polar_ff[gi]),
        .edge_ff(edge_hit[gi]),
        .low_count(low_cnt[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // ahb-lite register access
  // ----------------------------------------
  assign addr_ph = hsel && hready && htrans[1];
  assign flag_clr = wr_hit(wr_pend_ff, wr_addr_ff, `PPF_OFS_IRQ_CLR) ? hwdata[N-1:0] : {N{1'b0}};

  // zero wait states: ready and an okay response stand after reset
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 12'h000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_ff <= addr_ph && hwrite;
      if (addr_ph) begin
        wr_addr_ff <= haddr;
      end
    end
  end

  // read data is taken in the address phase and stands until the next read
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      hrdata <= `PPF_RSVD_READ;
    end else if (addr_ph && !hwrite) begin
      hrdata <= `PPF_RSVD_READ;
      if (is_rsvd(haddr)) begin
        hrdata <= `PPF_RSVD_READ;
      end else begin
        case (haddr)
          `PPF_OFS_PULLUP: hrdata[N-1:0] <= pullup_ff;
          `PPF_OFS_DATA: hrdata[N-1:0] <= data_ff;
          `PPF_OFS_DIR: hrdata[N-1:0] <= dir_ff;
          `PPF_OFS_PERSEL: hrdata[N-1:0] <= persel_ff;
          `PPF_OFS_IRQ_EN: hrdata[N-1:0] <= irq_en_ff;
          `PPF_OFS_IRQ_STAT: hrdata[N-1:0] <= flag_ff;
          `PPF_OFS_POLAR: hrdata[N-1:0] <= polar_ff;
          `PPF_OFS_INPUT: hrdata[N-1:0] <= sync2_ff;
          `PPF_OFS_MODE: hrdata[`PPF_MODE_STOP_BIT] <= stop_mode;
          default: hrdata <= `PPF_RSVD_READ;
        endcase
      end
    end
  end

  // ----------------------------------------
  // interrupt flags
  // ----------------------------------------
  // set wins when an edge and its clear land in one cycle
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_ff <= `PPF_RST_BYTE;
    end else begin
      flag_ff <= (flag_ff & ~flag_clr) | edge_hit;
    end
  end

  // ----------------------------------------
  // pull-up enables
  // ----------------------------------------
  // masked at the pin while that pin drives
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pullup_ff <= `PPF_RST_BYTE;
    end else if (wr_hit(wr_pend_ff, wr_addr_ff, `PPF_OFS_PULLUP)) begin
      pullup_ff <= hwdata[N-1:0];
    end
  end

  // ----------------------------------------
  // port data
  // ----------------------------------------
  // shows on a pin once its direction drives
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      data_ff <= `PPF_RST_BYTE;
    end else if (wr_hit(wr_pend_ff, wr_addr_ff, `PPF_OFS_DATA)) begin
      data_ff <= hwdata[N-1:0];
    end
  end

  // ----------------------------------------
  // data direction
  // ----------------------------------------
  // pins outside the gpio mask never drive from this
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dir_ff <= `PPF_RST_BYTE;
    end else if (wr_hit(wr_pend_ff, wr_addr_ff, `PPF_OFS_DIR)) begin
      dir_ff <= hwdata[N-1:0];
    end
  end

  // ----------------------------------------
  // peripheral select
  // ----------------------------------------
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      persel_ff <= `PPF_RST_BYTE;
    end else if (wr_hit(wr_pend_ff, wr_addr_ff, `PPF_OFS_PERSEL)) begin
      persel_ff <= hwdata[N-1:0];
    end
  end

  // ----------------------------------------
  // interrupt enables
  // ----------------------------------------
  // enables gate the request and the stop-mode oscillator, flags set regardless
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_en_ff <= `PPF_RST_BYTE;
    end else if (wr_hit(wr_pend_ff, wr_addr_ff, `PPF_OFS_IRQ_EN)) begin
      irq_en_ff <= hwdata[N-1:0];
    end
  end

  // ----------------------------------------
  // edge polarity
  // ----------------------------------------
  // a set bit makes the high level the active one
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      polar_ff <= `PPF_RST_BYTE;
    end else if (wr_hit(wr_pend_ff, wr_addr_ff, `PPF_OFS_POLAR)) begin
      polar_ff <= hwdata[N-1:0];
    end
  end

  // reserved offsets match no block above and keep no state

endmodule

`default_nettype wire

// File: src/ppf_rc_osc.v
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// gated stop-mode sample tick source
// ----------------------------------------
// models the local rc oscillator as a divided enable pulse that only
// runs while run is high
module ppf_rc_osc #(
  parameter DIV = 4
) (
  // clock and reset
  input wire core_clk,
  input wire reset_n,
  // control
  input wire run,
  // tick
  output reg tick_ff
);

  reg [7:0] div_ff;

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_ff <= 8'h00;
      tick_ff <= 1'b0;
    end else if (!run) begin
      div_ff <= 8'h00;
      tick_ff <= 1'b0;
    end else if (div_ff == DIV[7:0] - 8'h01) begin
      div_ff <= 8'h00;
      tick_ff <= 1'b1;
    end else begin
      div_ff <= div_ff + 8'h01;
      tick_ff <= 1'b0;
    end
  end

endmodule

`default_nettype wire
